// >>> design/alu_pkg.sv
// Functional notes
// - Add register, working reg and carry.
// - Add and AND register ops: destination zero working reg, one register.
// - Add register and working reg, no carry.
// - Add immediate plus carry into working reg.
// - Add immediate into working reg, no carry.
// - AND register, only zero flag changes.
// - AND immediate into working reg, zero only.
// - Clear selected bit, flags unchanged.
// - Set selected bit, flags unchanged.
// - Carry flag follows carry out of bit seven.
// - Register index is six bits wide.
package alu_pkg;

  localparam int DATA_W = 8;
  localparam int REG_IDX_W = 6;
  localparam logic [7:0] WORKING_REG_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [5:0] REG_IDX_RESET = 6'h00;
  localparam int NIBBLE_CARRY_POS = 4;
  localparam int CARRY_POS = 8;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADD_REG_CARRY,
    OP_ADD_REG,
    OP_ADD_IMM_CARRY,
    OP_ADD_IMM,
    OP_BITWISE_AND_REG,
    OP_BITWISE_AND_IMM,
    OP_BIT_CLEAR_REG,
    OP_BIT_SET_REG
  } alu_op_t;

  typedef struct packed {
    logic zero;
    logic lowNibbleOverflow;
    logic carry;
  } alu_flags_t;

  localparam alu_flags_t FLAGS_RESET = '0;

  typedef struct packed {
    alu_op_t op;
    logic [5:0] regIdx;
    logic [7:0] regOperand;
    logic [7:0] immediate;
    logic destSel;
    logic [2:0] bitSel;
  } alu_cmd_t;

endpackage : alu_pkg

// >>> design/acc_add_and_bit_alu.sv
`timescale 1ns/1ps
module acc_add_and_bit_alu
  import alu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cmdValid,
  input alu_cmd_t cmd,
  output logic [7:0] workingReg,
  output alu_flags_t flags,
  output logic regWrite,
  output logic [5:0] regWriteIdx,
  output logic [7:0] regWriteData,
  output logic done
);

  logic [7:0] workingReg_d;
  alu_flags_t flags_d;
  logic regWrite_d;
  logic [7:0] result;
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic carryIn;
  logic isAdd;
  logic isAnd;
  logic isBit;
  logic useImm;

  // Adds two bytes and a carry, returning the nine-bit sum.
  function automatic logic [8:0] add8(input logic [7:0] a, input logic [7:0] b, input logic c);
    add8 = {1'b0, a} + {1'b0, b} + {8'h00, c};
  endfunction : add8

  // Decodes the operation class, operand source and carry use.
  always_comb begin
    isAdd = 1'b0;
    isAnd = 1'b0;
    isBit = 1'b0;
    useImm = 1'b0;
    carryIn = 1'b0;
    unique case (cmd.op)
      OP_ADD_REG_CARRY: begin
        isAdd = 1'b1;
        carryIn = flags.carry;
      end
      OP_ADD_REG: isAdd = 1'b1;
      OP_ADD_IMM_CARRY: begin
        isAdd = 1'b1;
        useImm = 1'b1;
        carryIn = flags.carry;
      end
      OP_ADD_IMM: begin
        isAdd = 1'b1;
        useImm = 1'b1;
      end
      OP_BITWISE_AND_REG: isAnd = 1'b1;
      OP_BITWISE_AND_IMM: begin
        isAnd = 1'b1;
        useImm = 1'b1;
      end
      OP_BIT_CLEAR_REG, OP_BIT_SET_REG: isBit = 1'b1;
      default: begin
      end
    endcase
  end

  // Forms the result of the operation from the chosen operands.
  always_comb begin
    logic [7:0] opB;
    opB = useImm ? cmd.immediate : cmd.regOperand;
    sum = add8(workingReg, opB, carryIn);
    lowSum = {1'b0, workingReg[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    if (isAdd) begin
      result = sum[7:0];
    end else if (isAnd) begin
      result = workingReg & opB;
    end else if (cmd.op == OP_BIT_CLEAR_REG) begin
      result = cmd.regOperand & ~(8'h01 << cmd.bitSel);
    end else if (cmd.op == OP_BIT_SET_REG) begin
      result = cmd.regOperand | (8'h01 << cmd.bitSel);
    end else begin
      result = cmd.regOperand;
    end
  end

  // Steers the result and computes next flag values.
  always_comb begin
    workingReg_d = workingReg;
    flags_d = flags;
    regWrite_d = 1'b0;
    if (cmdValid && (isAdd || isAnd || isBit)) begin
      if (isBit) begin
        regWrite_d = 1'b1;
      end else if (useImm || !cmd.destSel) begin
        workingReg_d = result;
      end else begin
        regWrite_d = 1'b1;
      end
      if (isAdd || isAnd) begin
        flags_d.zero = (result == 8'h00);
      end
      if (isAdd) begin
        flags_d.carry = sum[CARRY_POS];
        flags_d.lowNibbleOverflow = lowSum[NIBBLE_CARRY_POS];
      end
    end
  end

  // Working register and flags.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      workingReg <= WORKING_REG_RESET;
      flags <= FLAGS_RESET;
    end else begin
      workingReg <= workingReg_d;
      flags <= flags_d;
    end
  end

  // Register write-back port, one cycle after the command.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regWrite <= 1'b0;
      regWriteIdx <= REG_IDX_RESET;
      regWriteData <= RESULT_RESET;
      done <= 1'b0;
    end else begin
      regWrite <= regWrite_d;
      regWriteIdx <= cmd.regIdx;
      regWriteData <= result;
      done <= cmdValid && (isAdd || isAnd || isBit); // An unused op code is refused like no-op.
    end
  end

  // Each check looks one cycle after the command was taken.
  AST_ADD_CARRY: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_IMM |=>
    flags.carry == (({1'b0, $past(workingReg)} + {1'b0, $past(cmd.immediate)}) > 9'h0ff))
    else $error("Carry flag wrong after add.");

  AST_ADD_REG_CARRY: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_REG_CARRY && !cmd.destSel |=>
    workingReg == 8'($past(workingReg) + $past(cmd.regOperand) + 8'($past(flags.carry))))
    else $error("Add with carry result wrong.");

  AST_DEST_REG: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_REG && cmd.destSel |=> regWrite && $stable(workingReg))
    else $error("Destination one did not write register.");

  AST_ADD_REG_NOCARRY: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_REG && !cmd.destSel |=>
    workingReg == 8'($past(workingReg) + $past(cmd.regOperand)))
    else $error("Plain add used carry.");

  AST_IMM_CARRY: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_IMM_CARRY |=>
    workingReg == 8'($past(workingReg) + $past(cmd.immediate) + 8'($past(flags.carry))))
    else $error("Immediate add with carry wrong.");

  AST_AND_FLAGS: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && isAnd |=> $stable(flags.carry) && $stable(flags.lowNibbleOverflow))
    else $error("AND changed arithmetic flags.");

  AST_AND_IMM: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_BITWISE_AND_IMM |=>
    workingReg == ($past(workingReg) & $past(cmd.immediate)) && flags.zero == (workingReg == 8'h00))
    else $error("AND immediate wrong.");

  AST_BIT_OPS: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_BIT_CLEAR_REG |=> regWrite && $stable(flags)
    && regWriteData == ($past(cmd.regOperand) & ~(8'h01 << $past(cmd.bitSel))))
    else $error("Bit clear wrong.");

  AST_BIT_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_BIT_SET_REG |=> regWrite && $stable(flags)
    && regWriteData == ($past(cmd.regOperand) | (8'h01 << $past(cmd.bitSel))))
    else $error("Bit set wrong.");

  AST_DEST_ACC: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_BITWISE_AND_REG && !cmd.destSel |=> !regWrite)
    else $error("Register written for working-reg destination.");

  // Plain immediate add ignores the carry flag and lands in the working register.
  AST_ADD_IMM: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_IMM |=>
    workingReg == 8'($past(workingReg) + $past(cmd.immediate)))
    else $error("Plain immediate add wrong.");

  // The write-back index is the six-bit register index of the command.
  AST_REG_INDEX: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_BIT_SET_REG |=> regWriteIdx == $past(cmd.regIdx))
    else $error("Write-back index wrong.");

  // Zero flag reflects an all-zero sum.
  AST_ZERO_FLAG: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_IMM |=> flags.zero == (workingReg == 8'h00))
    else $error("Zero flag wrong after add.");

  // Nibble flag is the carry out of bit three.
  AST_NIBBLE_FLAG: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_REG |=>
    flags.lowNibbleOverflow ==
    (({1'b0, $past(workingReg[3:0])} + {1'b0, $past(cmd.regOperand[3:0])}) > 5'h0f))
    else $error("Nibble carry flag wrong.");

  // Every legal command finishes in the cycle after it is taken.
  AST_DONE_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op != OP_NONE && cmd.op <= OP_BIT_SET_REG |=> done)
    else $error("Command did not finish in one cycle.");

  // A working-reg destination must not disturb the register operand.
  AST_REG_KEEP: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_REG_CARRY && !cmd.destSel |=> !regWrite)
    else $error("Register written by add with carry to working reg.");

  // Destination one carries the sum back to the register.
  AST_DEST_REG_DATA: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_ADD_REG && cmd.destSel |=>
    regWriteData == 8'($past(workingReg) + $past(cmd.regOperand)))
    else $error("Register write-back data wrong.");

  // Register-operand AND with destination one goes back to the register only.
  AST_AND_REG_DEST: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdValid && cmd.op == OP_BITWISE_AND_REG && cmd.destSel |=> regWrite && $stable(workingReg)
    && regWriteData == ($past(workingReg) & $past(cmd.regOperand)))
    else $error("AND register result wrong.");

endmodule : acc_add_and_bit_alu

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import alu_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmdValid = 1'b0;
  alu_cmd_t cmd = '0;
  logic [7:0] workingReg, regWriteData, acc = 8'h00;
  logic [5:0] regWriteIdx;
  logic regWrite, done;
  alu_flags_t flags, fl = '0;
  logic [31:0] seed = 32'h19;
  logic [25:0] e;
  logic [25:0] q[$];
  int num_errors = 0;
  int samples_checked = 0;

  // Free-running clock, 10 ns period.
  always #5 sys_clk = ~sys_clk;

  acc_add_and_bit_alu acc_add_and_bit_alu_inst (.sys_clk(sys_clk), .resetn(resetn),
    .cmdValid(cmdValid), .cmd(cmd), .workingReg(workingReg), .flags(flags),
    .regWrite(regWrite), .regWriteIdx(regWriteIdx), .regWriteData(regWriteData), .done(done));

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Drives one random command and notes the expected outcome from a reference model.
  task automatic drive();
    logic [31:0] r, t;
    alu_cmd_t c;
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] x, res;
    logic cy, wr, v;
    alu_flags_t f;
    r = xorshift();
    t = xorshift();
    c = {alu_op_t'(r[3:0] % 4'h9), r[9:4], r[17:10], r[25:18], r[26], r[29:27]};
    if (t[1:0] == 2'h0) begin
      c.regOperand = 8'hff;
      c.immediate = {7'h00, t[2]};
    end
    v = r[30] | r[31];
    x = c.op inside {OP_ADD_REG_CARRY, OP_ADD_REG, OP_BITWISE_AND_REG, OP_BIT_CLEAR_REG,
      OP_BIT_SET_REG} ? c.regOperand : c.immediate;
    cy = (c.op inside {OP_ADD_REG_CARRY, OP_ADD_IMM_CARRY}) & fl.carry;
    s = {1'b0, acc} + {1'b0, x} + {8'h00, cy};
    n = {1'b0, acc[3:0]} + {1'b0, x[3:0]} + {4'h0, cy};
    case (c.op)
      OP_BITWISE_AND_REG, OP_BITWISE_AND_IMM: begin
        res = acc & x;
        f = {res == 8'h00, fl.lowNibbleOverflow, fl.carry};
      end
      OP_BIT_CLEAR_REG: begin
        res = x & ~(8'h01 << c.bitSel);
        f = fl;
      end
      OP_BIT_SET_REG: begin
        res = x | (8'h01 << c.bitSel);
        f = fl;
      end
      default: begin
        res = s[7:0];
        f = {s[7:0] == 8'h00, n[4], s[8]};
      end
    endcase
    wr = c.op inside {OP_BIT_CLEAR_REG, OP_BIT_SET_REG} ||
      (c.op inside {OP_ADD_REG_CARRY, OP_ADD_REG, OP_BITWISE_AND_REG} && c.destSel);
    cmdValid <= v;
    cmd <= c;
    if (v && c.op != OP_NONE) begin
      if (!wr) acc = res;
      fl = f;
      q.push_back({acc, f, wr, c.regIdx, res});
    end
  endtask : drive

  // Takes the oldest note whenever a result appears and compares it.
  always @(posedge sys_clk) begin
    #1;
    if (resetn && done === 1'b1) begin
      if (q.size() == 0) begin
        chk("spurious done", 8'h01, 8'h00);
      end else begin
        e = q.pop_front();
        chk("workingReg", workingReg, e[25:18]);
        chk("flags", {5'h00, flags}, {5'h00, e[17:15]});
        chk("regWrite", {7'h00, regWrite}, {7'h00, e[14]});
        if (e[14]) begin
          chk("regWriteIdx", {2'h0, regWriteIdx}, {2'h0, e[13:8]});
          chk("regWriteData", regWriteData, e[7:0]);
        end
      end
    end else if (resetn) begin
      chk("idle regWrite", {7'h00, regWrite}, 8'h00);
    end
  end

  // Watchdog against a hang.
  initial begin
    #40000;
    num_errors++;
    stop_test();
  end

  // Reset check, then back-to-back random commands.
  initial begin
    repeat (2) @(posedge sys_clk);
    chk("reset workingReg", workingReg, WORKING_REG_RESET);
    chk("reset flags", {5'h00, flags}, 8'h00);
    resetn <= 1'b1;
    $display("test reset done");
    repeat (3000) @(posedge sys_clk) drive();
    @(posedge sys_clk) cmdValid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("pending results", 8'(q.size()), 8'h00);
    $display("test random done");
    stop_test();
  end
endmodule : tb
